// ---- exec_timing_pkg.sv ----
// constants for the instruction timing core with dual data pointers
// assumes one 20 MHz core clock and a 32-bit Avalon-MM register port
package exec_timing_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int CLKS_PER_ICYC = 4;
  localparam int TIMER_SLOW_DIV = 12;
  localparam int TIMER_FAST_DIV = 4;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PTR0_LO = 8'h82;
  localparam logic [7:0] IDX_PTR0_HI = 8'h83;
  localparam logic [7:0] IDX_PTR1_LO = 8'h84;
  localparam logic [7:0] IDX_PTR1_HI = 8'h85;
  localparam logic [7:0] IDX_SEL = 8'h86;
  localparam logic [7:0] IDX_SPEED = 8'h8e;

  localparam logic [7:0] RST_PTR = 8'h00;
  localparam logic [7:0] RST_SEL = 8'h00;
  localparam logic [7:0] RST_SPEED = 8'h01;

  localparam int SEL_BIT = 0;
  localparam int MD_LSB = 0;
  localparam int MD_MSB = 2;
  localparam int T0M_BIT = 3;
  localparam int XMOVE_BASE_CYC = 2;

  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_NOP_ALT = 8'ha5;
  localparam logic [7:0] OP_PTR_LOAD = 8'h90;
  localparam logic [7:0] OP_CODE_PTR = 8'h93;
  localparam logic [7:0] OP_CODE_PC = 8'h83;
  localparam logic [7:0] OP_XRD16 = 8'he0;
  localparam logic [7:0] OP_XWR16 = 8'hf0;
  localparam logic [7:0] OP_JMP_IND = 8'h73;
  localparam logic [7:0] OP_LONG_CALL = 8'h12;
  localparam logic [7:0] OP_LJMP = 8'h02;
  localparam logic [7:0] OP_RET = 8'h22;
  localparam logic [7:0] OP_INTERRUPT_RETURN = 8'h32;
endpackage

// ---- cpu_exec_timing_dual_data_pointer.sv ----
// instruction timing sequencer, dual data pointers and timer prescale
// assumes a fetch unit presents opcodes with valid/ready on core_clk
`timescale 1ns/1ns
module cpu_exec_timing_dual_data_pointer
  import exec_timing_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic op_valid,
  input wire logic [7:0] opcode,
  output logic op_ready,
  input wire logic [7:0] acc_value,
  input wire logic [7:0] ri_value,
  input wire logic [7:0] mem_value,
  input wire logic [15:0] pc_value,
  input wire logic [15:0] imm_value,
  input wire logic core_sfr_we,
  input wire logic [7:0] core_sfr_addr,
  input wire logic [7:0] core_sfr_wdata,
  output logic icyc_strobe,
  output logic instr_done,
  output logic [1:0] instr_bytes,
  output logic [3:0] instr_cycles,
  output logic opcode_known,
  output logic xdata_rd,
  output logic xdata_wr,
  output logic [15:0] xdata_addr,
  output logic code_rd,
  output logic [15:0] code_addr,
  output logic [15:0] jump_addr,
  output logic [7:0] nib_acc,
  output logic [7:0] nib_mem,
  output logic pointer_sel,
  output logic [2:0] timer_tick
);
  typedef enum logic [1:0] {st_idle = 2'b01, st_exec = 2'b10} seq_state_t;

  logic [1:0] rst_pipe;
  logic rst_sync_n;
  seq_state_t state;
  logic [1:0] phase;
  logic [3:0] cyc_cnt;
  logic [7:0] cur_op;
  logic [7:0] pointer0_low_byte;
  logic [7:0] pointer0_high_byte;
  logic [7:0] pointer1_low_byte;
  logic [7:0] pointer1_high_byte;
  logic [7:0] speed_control;
  logic [15:0] data_pointer;
  logic [2:0] move_stretch;
  logic [6:0] dec;
  logic accept;
  logic bus_req;
  logic bus_ack;
  logic bus_wr;
  logic [7:0] bus_idx;
  logic [3:0] presc;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  function automatic logic is_xmove(input logic [7:0] op);
    is_xmove = (op == OP_XRD16) || (op == OP_XWR16) ||
               (op[7:1] == 7'b1110_001) || (op[7:1] == 7'b1111_001);
  endfunction

  // {known, bytes, cycles}; an unlisted opcode is timed as one byte, one cycle
  function automatic logic [6:0] decode(input logic [7:0] op, input logic [2:0] md);
    logic [3:0] xcyc;
    xcyc = 4'(XMOVE_BASE_CYC) + {1'b0, md};
    decode = {1'b0, 2'd1, 4'd1};
    casez (op)
      8'h00, 8'ha5: decode = {1'b1, 2'd1, 4'd1};
      8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3:
        decode = {1'b1, 2'd1, xcyc};
      8'h93, 8'h83: decode = {1'b1, 2'd1, 4'd3};
      8'h76, 8'h77: decode = {1'b1, 2'd2, 4'd2};
      8'h90: decode = {1'b1, 2'd3, 4'd3};
      8'hc0, 8'hd0: decode = {1'b1, 2'd2, 4'd2};
      8'b1100_1???, 8'hc6, 8'hc7: decode = {1'b1, 2'd1, 4'd1};
      8'hc5: decode = {1'b1, 2'd2, 4'd2};
      8'hd6, 8'hd7: decode = {1'b1, 2'd1, 4'd1};
      8'b???1_0001: decode = {1'b1, 2'd2, 4'd3};
      8'h12: decode = {1'b1, 2'd3, 4'd4};
      8'h22, 8'h32: decode = {1'b1, 2'd1, 4'd4};
      8'b???0_0001: decode = {1'b1, 2'd2, 4'd3};
      8'h02: decode = {1'b1, 2'd3, 4'd4};
      8'h80: decode = {1'b1, 2'd2, 4'd3};
      8'h40, 8'h50: decode = {1'b1, 2'd2, 4'd3};
      8'h60, 8'h70: decode = {1'b1, 2'd2, 4'd3};
      8'h10, 8'h20, 8'h30: decode = {1'b1, 2'd3, 4'd4};
      8'h73: decode = {1'b1, 2'd1, 4'd3};
      8'b1011_01??, 8'b1011_1???: decode = {1'b1, 2'd3, 4'd4};
      8'b1101_1???: decode = {1'b1, 2'd2, 4'd3};
      8'hd5: decode = {1'b1, 2'd3, 4'd4};
      default: decode = {1'b0, 2'd1, 4'd1};
    endcase
  endfunction

  function automatic logic [7:0] sfr_read(input logic [7:0] idx, input logic [7:0] p0l,
                                          input logic [7:0] p0h, input logic [7:0] p1l,
                                          input logic [7:0] p1h, input logic sel,
                                          input logic [7:0] spd);
    case (idx)
      IDX_PTR0_LO: sfr_read = p0l;
      IDX_PTR0_HI: sfr_read = p0h;
      IDX_PTR1_LO: sfr_read = p1l;
      IDX_PTR1_HI: sfr_read = p1h;
      IDX_SEL: sfr_read = {7'h00, sel};
      IDX_SPEED: sfr_read = spd;
      default: sfr_read = 8'h00;
    endcase
  endfunction

  assign move_stretch = speed_control[MD_MSB:MD_LSB];
  assign dec = decode(opcode, move_stretch);
  assign data_pointer = pointer_sel ? {pointer1_high_byte, pointer1_low_byte}
                                    : {pointer0_high_byte, pointer0_low_byte};

  // avalon slave: one wait state, then the access completes
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~bus_ack;
  assign bus_wr = avs_write & bus_ack & avs_byteenable[0];
  assign bus_idx = avs_address[9:2];

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
      if (avs_read && !bus_ack) begin
        avs_readdata <= {24'h00_0000, sfr_read(bus_idx, pointer0_low_byte,
          pointer0_high_byte, pointer1_low_byte, pointer1_high_byte,
          pointer_sel, speed_control)};
      end
    end
  end

  // sequencer
  assign op_ready = (state == st_idle);
  assign accept = op_ready & op_valid;
  assign icyc_strobe = (state == st_exec) && (phase == 2'd3);
  assign instr_done = icyc_strobe && (cyc_cnt == instr_cycles);

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= st_idle;
      phase <= 2'd0;
      cyc_cnt <= 4'd0;
    end else begin
      case (state)
        st_idle: begin
          if (op_valid) begin
            state <= st_exec;
            phase <= 2'd0;
            cyc_cnt <= 4'd1;
          end
        end
        st_exec: begin
          phase <= phase + 2'd1;
          if (phase == 2'd3) begin
            if (cyc_cnt == instr_cycles) begin
              state <= st_idle;
            end else begin
              cyc_cnt <= cyc_cnt + 4'd1;
            end
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // operands captured at accept so they stand for the whole instruction
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cur_op <= OP_NOP;
      instr_bytes <= 2'd0;
      instr_cycles <= 4'd0;
      opcode_known <= 1'b0;
      xdata_addr <= 16'h0000;
      code_addr <= 16'h0000;
      jump_addr <= 16'h0000;
      nib_acc <= 8'h00;
      nib_mem <= 8'h00;
    end else if (accept) begin
      cur_op <= opcode;
      {opcode_known, instr_bytes, instr_cycles} <= dec;
      if (opcode == OP_XRD16 || opcode == OP_XWR16) begin
        xdata_addr <= data_pointer;
      end else begin
        xdata_addr <= {8'h00, ri_value};
      end
      if (opcode == OP_CODE_PC) begin
        code_addr <= pc_value + {8'h00, acc_value};
      end else begin
        code_addr <= data_pointer + {8'h00, acc_value};
      end
      jump_addr <= data_pointer + {8'h00, acc_value};
      nib_acc <= {acc_value[7:4], mem_value[3:0]};
      nib_mem <= {mem_value[7:4], acc_value[3:0]};
    end
  end

  // strobes held for the whole instruction, dropped after its last clock
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      xdata_rd <= 1'b0;
      xdata_wr <= 1'b0;
      code_rd <= 1'b0;
    end else if (accept) begin
      xdata_rd <= is_xmove(opcode) & ~opcode[4];
      xdata_wr <= is_xmove(opcode) & opcode[4];
      code_rd <= (opcode == OP_CODE_PTR) || (opcode == OP_CODE_PC);
    end else if (instr_done) begin
      xdata_rd <= 1'b0;
      xdata_wr <= 1'b0;
      code_rd <= 1'b0;
    end
  end

  // pointer file; bus write wins over a core write in the same cycle
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pointer0_low_byte <= RST_PTR;
      pointer0_high_byte <= RST_PTR;
      pointer1_low_byte <= RST_PTR;
      pointer1_high_byte <= RST_PTR;
    end else if (bus_wr) begin
      if (bus_idx == IDX_PTR0_LO) pointer0_low_byte <= avs_writedata[7:0];
      if (bus_idx == IDX_PTR0_HI) pointer0_high_byte <= avs_writedata[7:0];
      if (bus_idx == IDX_PTR1_LO) pointer1_low_byte <= avs_writedata[7:0];
      if (bus_idx == IDX_PTR1_HI) pointer1_high_byte <= avs_writedata[7:0];
    end else if (core_sfr_we) begin
      if (core_sfr_addr == IDX_PTR0_LO) pointer0_low_byte <= core_sfr_wdata;
      if (core_sfr_addr == IDX_PTR0_HI) pointer0_high_byte <= core_sfr_wdata;
      if (core_sfr_addr == IDX_PTR1_LO) pointer1_low_byte <= core_sfr_wdata;
      if (core_sfr_addr == IDX_PTR1_HI) pointer1_high_byte <= core_sfr_wdata;
    end else if (instr_done && cur_op == OP_PTR_LOAD) begin
      if (pointer_sel) begin
        {pointer1_high_byte, pointer1_low_byte} <= imm_value;
      end else begin
        {pointer0_high_byte, pointer0_low_byte} <= imm_value;
      end
    end
  end

  // only bit 0 is kept, so an increment of the select register toggles it
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pointer_sel <= RST_SEL[SEL_BIT];
    end else if (bus_wr && bus_idx == IDX_SEL) begin
      pointer_sel <= avs_writedata[SEL_BIT];
    end else if (core_sfr_we && core_sfr_addr == IDX_SEL) begin
      pointer_sel <= core_sfr_wdata[SEL_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      speed_control <= RST_SPEED;
    end else if (bus_wr && bus_idx == IDX_SPEED) begin
      speed_control <= avs_writedata[7:0];
    end else if (core_sfr_we && core_sfr_addr == IDX_SPEED) begin
      speed_control <= core_sfr_wdata;
    end
  end

  // one shared divide-by-twelve; every third of it gives the fast rate
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      presc <= 4'd0;
    end else if (presc == 4'(TIMER_SLOW_DIV - 1)) begin
      presc <= 4'd0;
    end else begin
      presc <= presc + 4'd1;
    end
  end

  generate
    for (genvar t = 0; t < 3; t++) begin : g_timer
      always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          timer_tick[t] <= 1'b0;
        end else if (speed_control[T0M_BIT + t]) begin
          timer_tick[t] <= (presc[1:0] == 2'(TIMER_FAST_DIV - 1));
        end else begin
          timer_tick[t] <= (presc == 4'(TIMER_SLOW_DIV - 1));
        end
      end
    end
  endgenerate

  // checks
  logic [5:0] exec_clks;
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      exec_clks <= 6'd0;
    end else if (accept) begin
      exec_clks <= 6'd0;
    end else if (state == st_exec) begin
      exec_clks <= exec_clks + 6'd1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_n);

  sequence s_accept_op(logic [7:0] op);
    accept && opcode == op;
  endsequence

  sequence s_finish;
    instr_done;
  endsequence

  AST_ICYC_FOUR_CLOCKS: assert property (
    s_finish |-> exec_clks == {instr_cycles, 2'b00} - 6'd1)
    else $error("instruction length is not four clocks per cycle");

  AST_XMOVE_STRETCH: assert property (
    s_accept_op(OP_XRD16) |=> instr_cycles == 4'(XMOVE_BASE_CYC) + {1'b0, $past(move_stretch)})
    else $error("external move cycles do not follow speed bits");

  AST_XREAD_STROBE: assert property (
    accept && (opcode == 8'he2 || opcode == 8'he3) |=> xdata_rd && !xdata_wr
      && xdata_addr == {8'h00, $past(ri_value)})
    else $error("8-bit external read not decoded");

  AST_XWRITE_PTR: assert property (
    s_accept_op(OP_XWR16) |=> xdata_wr && !xdata_rd && xdata_addr == $past(data_pointer))
    else $error("16-bit external write not decoded");

  AST_CODE_READ: assert property (
    s_accept_op(OP_CODE_PTR) |=> code_rd && instr_cycles == 4'd3
      && code_addr == $past(data_pointer) + {8'h00, $past(acc_value)})
    else $error("code byte move address or length wrong");

  AST_PTR_LOAD: assert property (
    s_finish and (cur_op == OP_PTR_LOAD && !bus_wr && !core_sfr_we) |=>
      data_pointer == $past(imm_value))
    else $error("pointer load did not reach active pointer");

  AST_LONG_CALL: assert property (
    s_accept_op(OP_LONG_CALL) |=> instr_bytes == 2'd3 && instr_cycles == 4'd4 ##16 op_ready)
    else $error("long call length wrong");

  AST_RETURN: assert property (
    s_accept_op(OP_INTERRUPT_RETURN) |=> !op_ready [*8] ##8 !op_ready ##1 op_ready)
    else $error("interrupt return not four cycles");

  AST_NOP_ALT: assert property (
    s_accept_op(OP_NOP_ALT) |=> opcode_known && instr_cycles == 4'd1 ##4 op_ready)
    else $error("reserved opcode does not act as no-operation");

  AST_SEL_TOGGLE: assert property (
    core_sfr_we && core_sfr_addr == IDX_SEL && !bus_wr
      && core_sfr_wdata == {7'h00, pointer_sel} + 8'h01 |=> pointer_sel != $past(pointer_sel))
    else $error("select increment did not toggle");

  AST_TIMER_SLOW: assert property (
    timer_tick[0] && !speed_control[T0M_BIT] && !$past(speed_control[T0M_BIT])
      |=> (!timer_tick[0] || $past(speed_control[T0M_BIT])) [*8])
    else $error("slow timer ticks too often");
endmodule

// ---- prog_mem_model.sv ----
// program-memory side model: offers one opcode at a time on valid/ready
// assumes the core's decode port and memory strobes, all on core_clk
`timescale 1ns/1ns
module prog_mem_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [7:0] req_op,
  input wire logic op_ready,
  input wire logic instr_done,
  input wire logic strobe,
  output logic op_valid,
  output logic [7:0] opcode,
  output logic busy,
  output int lat,
  output int slen
);
  int cnt;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_valid <= 1'b0;
      opcode <= 8'h00;
      busy <= 1'b0;
      cnt <= 0;
      lat <= 0;
      slen <= 0;
    end else if (op_valid && op_ready) begin
      op_valid <= 1'b0;
      // released bus shows garbage, never the last opcode
      opcode <= ~opcode;
      cnt <= 0;
      slen <= 0;
    end else if (req && !busy) begin
      op_valid <= 1'b1;
      opcode <= req_op;
      busy <= 1'b1;
    end else if (busy && !op_valid) begin
      cnt <= cnt + 1;
      slen <= slen + int'(strobe);
      if (instr_done) begin
        lat <= cnt + 1;
        busy <= 1'b0;
      end
    end
  end
endmodule

// ---- tb_cpu_exec_timing_dual_data_pointer.sv ----
// self-checking bench for the timing core with dual data pointers
// assumes the design package and prog_mem_model are compiled first
`timescale 1ns/1ns
module tb_cpu_exec_timing_dual_data_pointer;
  import exec_timing_pkg::*;
  logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, op_valid, op_ready;
  logic core_sfr_we, icyc_strobe, instr_done, opcode_known, xdata_rd, xdata_wr, code_rd;
  logic pointer_sel, req, busy;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, instr_cycles;
  logic [1:0] instr_bytes;
  logic [2:0] timer_tick;
  logic [7:0] opcode, acc_value, ri_value, mem_value, core_sfr_addr, core_sfr_wdata, req_op;
  logic [7:0] nib_acc, nib_mem, v;
  logic [15:0] pc_value, imm_value, xdata_addr, code_addr, jump_addr;
  logic [7:0] ref_reg [256];
  int lat, slen, cyc, n0, n1, n2, icnt = 0, error_cnt = 0, cmp_count = 0;
  localparam logic [7:0] ids [7] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h8e, 8'h87};
  localparam logic [7:0] xops [6] = '{8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3};
  // opcode, bytes, instruction cycles
  localparam logic [23:0] tbl [42] = '{
    24'h000101, 24'ha50101, 24'h760202, 24'h770202, 24'h900303, 24'h930103, 24'h830103,
    24'hc00202, 24'hd00202, 24'hc50202, 24'hc60101, 24'hc70101, 24'hc80101, 24'hcf0101,
    24'hd60101, 24'hd70101, 24'h110203, 24'hf10203, 24'h120304, 24'h220104, 24'h320104,
    24'h010203, 24'he10203, 24'h020304, 24'h800203, 24'h400203, 24'h500203, 24'h600203,
    24'h700203, 24'h200304, 24'h300304, 24'h100304, 24'h730103, 24'hb50304, 24'hb40304,
    24'hb80304, 24'hbf0304, 24'hb60304, 24'hb70304, 24'hd80203, 24'hdf0203, 24'hd50304};

  cpu_exec_timing_dual_data_pointer uut (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .op_valid, .opcode,
    .op_ready, .acc_value, .ri_value, .mem_value, .pc_value, .imm_value, .core_sfr_we,
    .core_sfr_addr, .core_sfr_wdata, .icyc_strobe, .instr_done, .instr_bytes, .instr_cycles,
    .opcode_known, .xdata_rd, .xdata_wr, .xdata_addr, .code_rd, .code_addr, .jump_addr,
    .nib_acc, .nib_mem, .pointer_sel, .timer_tick);

  prog_mem_model pm (.core_clk, .rst_n, .req, .req_op, .op_ready, .instr_done,
    .strobe(xdata_rd | xdata_wr | code_rd), .op_valid, .opcode, .busy, .lat, .slen);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // instruction cycles seen since the last accept
  always @(posedge core_clk) begin
    if (op_valid && op_ready) icnt <= 0;
    else if (icyc_strobe === 1'b1) icnt <= icnt + 1;
  end

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_ex(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t exec got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] ptr();
    if (ref_reg[8'h86][0]) return {ref_reg[8'h85], ref_reg[8'h84]};
    return {ref_reg[8'h83], ref_reg[8'h82]};
  endfunction

  task automatic bus_wr(input logic [7:0] idx, input logic [7:0] dat, input logic [3:0] be);
    @(posedge core_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'($urandom()), dat};
    avs_byteenable <= be;
    avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    // only bit 0 of the select register stores
    if (be[0] && idx == 8'h86) ref_reg[idx] = {7'h00, dat[0]};
    else if (be[0] && idx inside {8'h82, 8'h83, 8'h84, 8'h85, 8'h8e}) ref_reg[idx] = dat;
  endtask

  task automatic bus_rd(input logic [7:0] idx);
    @(posedge core_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    chk_reg(avs_readdata, {24'h0, ref_reg[idx]});
    avs_read <= 1'b0;
  endtask

  task automatic run(input logic [7:0] op);
    @(posedge core_clk);
    acc_value <= 8'($urandom());
    ri_value <= 8'($urandom());
    mem_value <= 8'($urandom());
    pc_value <= 16'($urandom());
    imm_value <= 16'($urandom());
    req_op <= op;
    req <= 1'b1;
    @(posedge core_clk);
    req <= 1'b0;
    @(negedge core_clk);
    while (busy) @(negedge core_clk);
    if (op == 8'h90 && ref_reg[8'h86][0]) {ref_reg[8'h85], ref_reg[8'h84]} = imm_value;
    else if (op == 8'h90) {ref_reg[8'h83], ref_reg[8'h82]} = imm_value;
  endtask

  initial begin
    cyc = 0;
    forever begin
      @(posedge core_clk);
      cyc++;
      if (cyc == 20000) begin
        error_cnt++;
        summarize();
      end
    end
  end

  initial begin
    {rst_n, avs_read, avs_write, core_sfr_we, req} = '0;
    {avs_address, avs_writedata, avs_byteenable, core_sfr_addr, core_sfr_wdata} = '0;
    {acc_value, ri_value, mem_value, pc_value, imm_value, req_op} = '0;
    foreach (ref_reg[i]) ref_reg[i] = 8'h00;
    ref_reg[8'h8e] = 8'h01;
    void'($urandom(79));
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 7; i++) bus_rd(ids[i]);
    chk_ex(32'(pointer_sel), 32'h0);
    run(8'he0);
    chk_ex(32'(lat), 32'd12);
    $display("test reset done");
    for (int i = 0; i < 7; i++) bus_wr(ids[i], 8'($urandom()), 4'hf);
    for (int i = 0; i < 7; i++) bus_rd(ids[i]);
    bus_wr(8'h82, ~ref_reg[8'h82], 4'he);
    bus_rd(8'h82);
    repeat (2) begin
      // increment of the select register from the core side toggles the pointer
      @(posedge core_clk);
      core_sfr_addr <= 8'h86;
      core_sfr_wdata <= ref_reg[8'h86] + 8'h01;
      core_sfr_we <= 1'b1;
      @(posedge core_clk);
      core_sfr_we <= 1'b0;
      ref_reg[8'h86] = {7'h00, ~ref_reg[8'h86][0]};
      @(negedge core_clk);
      chk_ex(32'(pointer_sel), 32'(ref_reg[8'h86][0]));
      bus_rd(8'h86);
    end
    $display("test registers done");
    for (int i = 0; i < 42; i++) begin
      run(tbl[i][23:16]);
      chk_ex(32'(lat), 32'(4 * tbl[i][7:0]));
      chk_ex(32'(icnt), 32'(tbl[i][7:0]));
      chk_ex(32'(instr_cycles), 32'(tbl[i][3:0]));
      chk_ex(32'(instr_bytes), 32'(tbl[i][9:8]));
      chk_ex(32'(opcode_known), 32'h1);
    end
    // an opcode outside this block's table is timed as one unknown cycle
    run(8'ha4);
    chk_ex(32'(lat), 32'd4);
    chk_ex(32'({opcode_known, instr_bytes, instr_cycles}), 32'h11);
    $display("test opcode table done");
    for (int md = 0; md < 8; md++) begin
      bus_wr(8'h8e, {5'($urandom()), 3'(md)}, 4'hf);
      bus_wr(8'h86, 8'($urandom()), 4'hf);
      for (int k = 0; k < 6; k++) begin
        run(xops[k]);
        chk_ex(32'(lat), 32'(4 * (2 + md)));
        chk_ex(32'(slen), 32'(lat));
        chk_ex(32'(xdata_addr), xops[k][1] ? {24'h0, ri_value} : {16'h0, ptr()});
      end
    end
    $display("test external moves done");
    for (int s = 0; s < 2; s++) begin
      bus_wr(8'h86, 8'(s), 4'hf);
      run(8'h93);
      chk_ex(32'(code_addr), 32'(ptr() + {8'h00, acc_value}));
      run(8'h83);
      chk_ex(32'(code_addr), 32'(pc_value + {8'h00, acc_value}));
      run(8'h73);
      chk_ex(32'(jump_addr), 32'(ptr() + {8'h00, acc_value}));
      run(8'hd6);
      chk_ex(32'({nib_acc, nib_mem}), 32'({acc_value[7:4], mem_value[3:0],
        mem_value[7:4], acc_value[3:0]}));
      run(8'h90);
      for (int i = 0; i < 4; i++) bus_rd(ids[i]);
    end
    $display("test pointers done");
    for (int t = 0; t < 2; t++) begin
      v = t ? 8'h09 : 8'h31;
      bus_wr(8'h8e, v, 4'hf);
      repeat (4) @(negedge core_clk);
      n0 = 0;
      n1 = 0;
      n2 = 0;
      repeat (240) begin
        @(negedge core_clk);
        if (timer_tick[0] === 1'b1) n0++;
        if (timer_tick[1] === 1'b1) n1++;
        if (timer_tick[2] === 1'b1) n2++;
      end
      chk_ex(32'(n0), v[3] ? 32'd60 : 32'd20);
      chk_ex(32'(n1), v[4] ? 32'd60 : 32'd20);
      chk_ex(32'(n2), v[5] ? 32'd60 : 32'd20);
    end
    $display("test timers done");
    summarize();
  end
endmodule
